// ===== design/gpp_top.sv
// gpp_top: eight-pin and three-pin general-purpose port with AHB-Lite registers
`timescale 1ns/1ps
module gpp_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire gpp_pkg::gpp_ahb_req_t ahb_req,
  input  wire logic                  hrmw,
  output gpp_pkg::gpp_ahb_rsp_t      ahb_rsp,
  input  wire logic [7:0]            p7_pin_i,
  output gpp_pkg::gpp_p7_pad_t       p7_pad,
  input  wire logic [2:0]            pf_pin_i,
  output gpp_pkg::gpp_pf_pad_t       pf_pad,
  input  wire gpp_pkg::gpp_periph_t  p7_periph,
  output logic [7:0]                 p7_periph_in,
  output logic [2:0]                 pf_periph_in,
  input  wire logic                  standby_i,
  input  wire logic [2:0]            ext_irq_wake_en
);
  import gpp_pkg::*;

  typedef struct packed {
    gpp_bus_st_t  st;
    logic [7:0]   addr;
    logic         rmw;
    logic [31:0]  hrdata;
    logic [7:0]   p7_dat;
    logic [7:0]   p7_dir;
    logic [7:0]   p7_pul;
    logic [2:0]   pf_dat;
    logic [2:0]   pf_dir;
    logic [7:0]   ctl;
    gpp_p7_pad_t  p7_pad;
    gpp_pf_pad_t  pf_pad;
    logic [7:0]   p7_in;
    logic [2:0]   pf_in;
    logic         wr_seen;
  } gpp_top_st_t;

  gpp_top_st_t q;
  gpp_top_st_t d;

  logic [SYNC_W-1:0] pin_sync;
  logic              hiz;
  logic              take;
  logic [7:0]        wake_mask;
  logic [7:0]        p7_pin_c;
  logic [2:0]        pf_pin_c;
  logic [15:0]       p7_drv;
  logic [15:0]       pf_drv;
  logic [7:0]        p7_rd;
  logic [7:0]        pf_rd;

  // pad levels come from outside the clock domain
  gpp_sync #(
    .W (SYNC_W)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .async_i ({pf_pin_i, p7_pin_i}),
    .sync_o  (pin_sync)
  );

  // read mux: latch for rmw reads and for port-driven pins, else the pin
  function automatic logic [7:0] port_read(
    input logic [7:0] latch,
    input logic [7:0] dir,
    input logic [7:0] poe,
    input logic [7:0] pin,
    input logic       rmw
  );
    logic [7:0] sel_pin;
    sel_pin = rmw ? RST_BYTE : (~dir | poe);
    return (latch & ~sel_pin) | (pin & sel_pin);
  endfunction : port_read

  // pad drive: {oe, out}; peripheral wins, open-drain high floats
  function automatic logic [15:0] pad_drive(
    input logic [7:0] dat,
    input logic [7:0] dir,
    input logic [7:0] poe,
    input logic [7:0] pout,
    input logic [7:0] od,
    input logic       float_all
  );
    logic [7:0] val;
    logic [7:0] en;
    val = (poe & pout) | (~poe & dat);
    en  = (dir | poe) & {8{~float_all}};
    en  = en & ~(od & val);
    return {en, val};
  endfunction : pad_drive

  // pins in standby stay high-impedance only when the state bit asks for it;
  // with the bit clear, nothing below reacts to standby at all
  assign hiz = standby_i & q.ctl[CTL_SPL_BIT];

  // wake-capable inputs with their ext_irq_wake_en bit set keep listening so an edge can still leave standby
  always_comb begin
    wake_mask                 = RST_BYTE;
    wake_mask[P7_CNT_CLK_BIT] = ext_irq_wake_en[0];
    wake_mask[P7_SER_CLK_BIT] = ext_irq_wake_en[1];
    wake_mask[P7_SER_DIN_BIT] = ext_irq_wake_en[2];
  end

  // blocked inputs read low; avoids leakage through a floating pad
  always_comb begin
    p7_pin_c = pin_sync[P7_W-1:0] & (hiz ? wake_mask : 8'hff);
    pf_pin_c = pin_sync[SYNC_W-1:P7_W] & {PF_W{~hiz}};
    if (q.ctl[CTL_EXTERNAL_RESET_ENABLE_BIT]) begin
      pf_pin_c[PF_RST_BIT] = 1'b0;
    end
  end

  // an address phase is taken only when the bus is ready
  assign take = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready;

  // read values are formed from the state of the wait cycle
  assign p7_rd = port_read(q.p7_dat, q.p7_dir, p7_periph.oe, p7_pin_c, q.rmw);
  assign pf_rd = port_read({5'h00, q.pf_dat}, {5'h00, q.pf_dir}, RST_BYTE,
                           {5'h00, pf_pin_c}, q.rmw);

  // bus phases, register writes and pad state
  always_comb begin
    d = q;
    // data phase of a write: the latch stores whatever the direction
    if (q.st == ST_WRITE) begin
      d.wr_seen = 1'b1;
      unique case (q.addr)
        A_P7_DAT: d.p7_dat = ahb_req.hwdata[7:0];
        A_P7_DIR: d.p7_dir = ahb_req.hwdata[7:0];
        A_P7_PUL: d.p7_pul = ahb_req.hwdata[7:0] & P7_PULL_MASK;
        A_PF_DAT: d.pf_dat = ahb_req.hwdata[2:0];
        A_PF_DIR: d.pf_dir = ahb_req.hwdata[2:0];
        A_CTL:    d.ctl    = ahb_req.hwdata[7:0] & CTL_MASK;
        default:  d.wr_seen = 1'b1;
      endcase
    end
    unique case (q.st)
      ST_IDLE, ST_WRITE, ST_RDATA: begin
        if (take) begin
          d.addr = ahb_req.haddr[ADDR_W-1:0];
          d.rmw  = hrmw;
          d.st   = ahb_req.hwrite ? ST_WRITE : ST_READ;
        end else begin
          d.st = ST_IDLE;
        end
      end
      ST_READ: begin
        // one wait cycle lets a write in the previous data phase settle
        unique case (q.addr)
          A_P7_DAT: d.hrdata = {24'h000000, p7_rd};
          A_P7_DIR: d.hrdata = {24'h000000, q.p7_dir};
          A_P7_PUL: d.hrdata = {24'h000000, q.p7_pul};
          A_PF_DAT: d.hrdata = {24'h000000, pf_rd};
          A_PF_DIR: d.hrdata = {29'h00000000, q.pf_dir};
          A_CTL:    d.hrdata = {24'h000000, q.ctl};
          default:  d.hrdata = RST_WORD;
        endcase
        d.st = ST_RDATA;
      end
    endcase
    // pad outputs follow the next register values so a write shows at once;
    // formed inside this process so no net loops from d back into it
    p7_drv = pad_drive(d.p7_dat, d.p7_dir, p7_periph.oe, p7_periph.out,
                       P7_OPEN_DRAIN, hiz);
    pf_drv = pad_drive({5'h00, d.pf_dat}, {5'h00, d.pf_dir}, RST_BYTE,
                       RST_BYTE, {5'h00, PF_OPEN_DRAIN}, hiz);
    // pad state; the reset pin never drives while it serves as reset
    d.p7_pad.out = p7_drv[7:0];
    d.p7_pad.oe  = p7_drv[15:8];
    // pull-up drops whenever the pin is actively low
    d.p7_pad.pull = d.p7_pul & P7_PULL_MASK & ~(p7_drv[15:8] & ~p7_drv[7:0]);
    d.pf_pad.out = pf_drv[2:0];
    d.pf_pad.oe  = pf_drv[10:8];
    if (d.ctl[CTL_EXTERNAL_RESET_ENABLE_BIT]) begin
      d.pf_pad.oe[PF_RST_BIT] = 1'b0;
    end
    // peripheral inputs see the same blocked levels as port reads
    d.p7_in = p7_pin_c;
    d.pf_in = pf_pin_c;
  end

  // latches reset low; direction low makes every pin an input unless its peripheral drives it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.p7_dir  <= RST_BYTE;
      q.pf_dir  <= 3'h0;
    end else begin
      q <= d;
    end
  end

  // bus answer: only the read wait cycle stalls, response is always okay
  assign ahb_rsp.hreadyout = (q.st != ST_READ);
  assign ahb_rsp.hresp     = HRESP_OKAY;
  assign ahb_rsp.hrdata    = q.hrdata;
  assign p7_pad            = q.p7_pad;
  assign pf_pad            = q.pf_pad;
  assign p7_periph_in      = q.p7_in;
  assign pf_periph_in      = q.pf_in;

  // checks on the port behaviour
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_DIR_RESET: assert property (
    !q.wr_seen |-> (q.p7_dir == RST_BYTE) && (q.pf_dir == 3'h0))
    else $error("direction not clear after reset");

  AST_OUT_DRIVE: assert property (
    !$past(p7_periph.oe[0]) && !$past(hiz)
    |-> (p7_pad.oe[0] == q.p7_dir[0]) && (!q.p7_dir[0] || p7_pad.out[0] == q.p7_dat[0]))
    else $error("port pin drive does not follow direction and latch");

  AST_WR_LATCH: assert property (
    (q.st == ST_WRITE) && (q.addr == A_P7_DAT)
    |=> (q.p7_dat == $past(ahb_req.hwdata[7:0])) && (p7_pad.oe == $past(p7_drv[15:8])))
    else $error("data write not stored in latch");

  AST_IN_NODRIVE: assert property (
    (q.p7_dir == RST_BYTE) && !$past(p7_periph.oe[1]) |-> !p7_pad.oe[1])
    else $error("input pin is being driven");

  AST_RD_RMW: assert property (
    (q.st == ST_READ) && q.rmw && (q.addr == A_P7_DAT)
    |=> (ahb_rsp.hrdata[7:0] == $past(q.p7_dat)) && ahb_rsp.hreadyout)
    else $error("rmw read did not return latch");

  AST_RD_PIN: assert property (
    (q.st == ST_READ) && !q.rmw && (q.addr == A_P7_DAT)
    |=> ((ahb_rsp.hrdata[7:0] ^ $past(p7_pin_c)) & ~$past(q.p7_dir)) == RST_BYTE)
    else $error("input pin read did not return pin level");

  AST_RD_PERIPH: assert property (
    (q.st == ST_READ) && !q.rmw && (q.addr == A_P7_DAT)
    |=> ((ahb_rsp.hrdata[7:0] ^ $past(p7_pin_c)) & $past(p7_periph.oe)) == RST_BYTE)
    else $error("peripheral pin read did not return pin level");

  AST_HIZ: assert property (
    $past(hiz) |-> (p7_pad.oe == RST_BYTE) && (pf_pad.oe == 3'h0))
    else $error("pin driven in standby high impedance");

  AST_PULL_LOW: assert property (
    (p7_pad.pull & p7_pad.oe & ~p7_pad.out) == RST_BYTE)
    else $error("pull-up on while driving low");

  AST_NO_PULL_BUS: assert property (
    (p7_pad.pull & ~P7_PULL_MASK) == RST_BYTE)
    else $error("pull-up on a bus pin");

  AST_OPEN_DRAIN: assert property (
    (p7_pad.oe & p7_pad.out & P7_OPEN_DRAIN) == RST_BYTE)
    else $error("open-drain pin driven high");

  AST_RST_PIN: assert property (
    q.ctl[CTL_EXTERNAL_RESET_ENABLE_BIT] && $past(q.ctl[CTL_EXTERNAL_RESET_ENABLE_BIT])
    |-> !pf_pad.oe[PF_RST_BIT] && !pf_periph_in[PF_RST_BIT])
    else $error("reset pin used as port");

  // the checks below pin down each pad and read path bit by bit
  AST_PF_IN_NODRIVE: assert property (
    (q.pf_dir == 3'h0) |-> (pf_pad.oe == 3'h0))
    else $error("three-pin input is being driven");

  AST_PF_DRIVE: assert property (
    !$past(hiz) && !q.ctl[CTL_EXTERNAL_RESET_ENABLE_BIT]
    |-> (pf_pad.out == q.pf_dat) && (pf_pad.oe == (q.pf_dir & ~(PF_OPEN_DRAIN & q.pf_dat))))
    else $error("three-pin drive does not follow direction and latch");

  AST_P7_DRIVE: assert property (
    !$past(hiz) && ($past(p7_periph.oe) == RST_BYTE)
    |-> (p7_pad.out == q.p7_dat) && (p7_pad.oe == (q.p7_dir & ~(P7_OPEN_DRAIN & q.p7_dat))))
    else $error("eight-pin drive does not follow direction and latch");

  AST_PERIPH_DRIVE: assert property (
    !$past(hiz)
    |-> (((p7_pad.out ^ $past(p7_periph.out)) & $past(p7_periph.oe)) == RST_BYTE)
        && ((~p7_pad.oe & $past(p7_periph.oe) & ~(P7_OPEN_DRAIN & $past(p7_periph.out))) == RST_BYTE))
    else $error("peripheral output not on its pin");

  AST_RD_LATCH: assert property (
    (q.st == ST_READ) && (q.addr == A_P7_DAT)
    |=> ((ahb_rsp.hrdata[7:0] ^ $past(q.p7_dat)) & $past(q.p7_dir & ~p7_periph.oe)) == RST_BYTE)
    else $error("output pin read did not return latch");

  AST_PF_RD: assert property (
    (q.st == ST_READ) && (q.addr == A_PF_DAT)
    |=> (ahb_rsp.hrdata[2:0] == $past(q.rmw ? q.pf_dat : ((q.pf_dat & q.pf_dir) | (pf_pin_c & ~q.pf_dir)))))
    else $error("three-pin read returned the wrong source");

  AST_PULL_ON: assert property (
    ((p7_pad.pull ^ q.p7_pul) & ~(p7_pad.oe & ~p7_pad.out)) == RST_BYTE)
    else $error("pull-up does not follow its register bit");

  AST_STBY_KEEP: assert property (
    !$past(hiz) |-> (p7_periph_in == $past(pin_sync[P7_W-1:0])))
    else $error("input blocked without standby high impedance");

  AST_STBY_BLOCK: assert property (
    $past(hiz) |-> ((p7_periph_in & ~$past(wake_mask)) == RST_BYTE) && (pf_periph_in == 3'h0))
    else $error("blocked input not held low in standby");

  AST_WAKE_LIVE: assert property (
    $past(hiz) |-> ((p7_periph_in ^ $past(pin_sync[P7_W-1:0])) & $past(wake_mask)) == RST_BYTE)
    else $error("wake-up input blocked in standby");

  AST_RMW_TAKE: assert property (
    take && !ahb_req.hwrite && (q.st != ST_READ) |=> (q.st == ST_READ) && (q.rmw == $past(hrmw)))
    else $error("read qualifier not captured with the address phase");

  AST_RD_ONE_WAIT: assert property (
    (q.st == ST_READ) |=> ahb_rsp.hreadyout && (q.st == ST_RDATA))
    else $error("read wait longer than one cycle");

  COV_WRITE:  cover property ((q.st == ST_WRITE) ##1 (q.st == ST_READ));
  COV_RMW:    cover property ((q.st == ST_READ) && q.rmw);
  COV_HIZ:    cover property (hiz && (q.p7_dir != RST_BYTE));
  COV_PERIPH: cover property ((p7_periph.oe != RST_BYTE) && (q.st == ST_READ));

endmodule : gpp_top

// ===== design/gpp_pkg.sv
// gpp_pkg: register map, field positions, carriers and state types of the port block
package gpp_pkg;

  // register byte offsets, decoded on haddr[7:0]
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] A_P7_DAT  = 8'h00;
  localparam logic [7:0] A_P7_DIR  = 8'h04;
  localparam logic [7:0] A_P7_PUL  = 8'h08;
  localparam logic [7:0] A_PF_DAT  = 8'h0c;
  localparam logic [7:0] A_PF_DIR  = 8'h10;
  localparam logic [7:0] A_CTL     = 8'h14;

  // port widths and per-pin features
  localparam int         P7_W          = 8;
  localparam int         PF_W          = 3;
  localparam int         SYNC_W        = P7_W + PF_W;
  localparam logic [7:0] P7_OPEN_DRAIN = 8'h0c;
  localparam logic [7:0] P7_PULL_MASK  = 8'hf3;
  localparam logic [2:0] PF_OPEN_DRAIN = 3'h4;
  localparam int         PF_RST_BIT    = 2;

  // pins whose input may stay live in standby for wake-up
  localparam int P7_CNT_CLK_BIT = 4;
  localparam int P7_SER_CLK_BIT = 5;
  localparam int P7_SER_DIN_BIT = 7;

  // control register fields
  localparam int         CTL_SPL_BIT   = 0;
  localparam int         CTL_EXTERNAL_RESET_ENABLE_BIT = 1;
  localparam logic [7:0] CTL_MASK      = 8'h03;

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic        HRESP_OKAY = 1'b0;

  // bus phase state, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WRITE = 4'b0010,
    ST_READ  = 4'b0100,
    ST_RDATA = 4'b1000
  } gpp_bus_st_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } gpp_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } gpp_ahb_rsp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } gpp_p7_pad_t;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } gpp_pf_pad_t;

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] out;
  } gpp_periph_t;

endpackage : gpp_pkg

// ===== design/gpp_sync.sv
// gpp_sync: two-flop synchroniser for the pad input levels
`timescale 1ns/1ps
module gpp_sync #(
  parameter int W = 11
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } gpp_sync_st_t;

  gpp_sync_st_t q;
  gpp_sync_st_t d;

  // the meta stage feeds only the stable stage
  always_comb begin
    d.meta   = async_i;
    d.stable = q.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.stable;

endmodule : gpp_sync

// ===== tb/gpp_pin_model.sv
// gpp_pin_model: board side of the pads, optional external drivers and board pull-ups
`timescale 1ns/1ps
module gpp_pin_model
  import gpp_pkg::*;
#(
  parameter logic [7:0] BRD_PULL7 = 8'h0c,
  parameter logic [2:0] BRD_PULLF = 3'h4
) (
  input  wire logic                 hclk,
  input  wire gpp_pkg::gpp_p7_pad_t p7_pad,
  input  wire gpp_pkg::gpp_pf_pad_t pf_pad,
  input  wire logic [7:0]           drv7_en,
  input  wire logic [7:0]           drv7_v,
  input  wire logic [2:0]           drvf_en,
  input  wire logic [2:0]           drvf_v,
  output logic [7:0]                p7_lvl,
  output logic [2:0]                pf_lvl
);
  import gpp_pkg::*;
  logic flt_q = 1'b0;

  // an undriven line with no pull wanders every cycle, so a stale level never passes
  always @(posedge hclk) begin
    flt_q <= ~flt_q;
  end

  // wire level: pad driver first, then the external driver, then pulls or the wander
  always_comb begin
    p7_lvl = (p7_pad.oe & p7_pad.out) | (~p7_pad.oe & drv7_en & drv7_v)
           | (~p7_pad.oe & ~drv7_en & (p7_pad.pull | BRD_PULL7 | {8{flt_q}}));
    pf_lvl = (pf_pad.oe & pf_pad.out) | (~pf_pad.oe & drvf_en & drvf_v)
           | (~pf_pad.oe & ~drvf_en & (BRD_PULLF | {3{flt_q}}));
  end
endmodule : gpp_pin_model

// ===== tb/gpp_top_tb.sv
// gpp_top_tb: register-level bench of the eight-pin and three-pin port
`timescale 1ns/1ps
module gpp_top_tb;
  import gpp_pkg::*;
  logic         hclk;
  logic         hresetn;
  gpp_ahb_req_t req_d;
  gpp_ahb_req_t req_w;
  gpp_ahb_rsp_t rsp;
  logic         hrmw;
  gpp_p7_pad_t  p7_pad;
  gpp_pf_pad_t  pf_pad;
  gpp_periph_t  periph;
  logic [7:0]   p7_lvl;
  logic [2:0]   pf_lvl;
  logic [7:0]   p7_to_per;
  logic [2:0]   pf_to_per;
  logic         standby;
  logic [2:0]   wake_en;
  logic [7:0]   drv7_en;
  logic [7:0]   drv7_v;
  logic [2:0]   drvf_en;
  logic [2:0]   drvf_v;
  logic [31:0]  rd;
  logic [7:0]   eo;
  int           bad_count;
  int           checks_done;

  // 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // the single slave's hreadyout is the bus hready
  always_comb begin
    req_w = req_d;
    req_w.hready = rsp.hreadyout;
  end

  gpp_top DUT (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .ahb_req         (req_w),
    .hrmw            (hrmw),
    .ahb_rsp         (rsp),
    .p7_pin_i        (p7_lvl),
    .p7_pad          (p7_pad),
    .pf_pin_i        (pf_lvl),
    .pf_pad          (pf_pad),
    .p7_periph       (periph),
    .p7_periph_in    (p7_to_per),
    .pf_periph_in    (pf_to_per),
    .standby_i       (standby),
    .ext_irq_wake_en (wake_en)
  );

  gpp_pin_model pins (
    .hclk    (hclk),
    .p7_pad  (p7_pad),
    .pf_pad  (pf_pad),
    .drv7_en (drv7_en),
    .drv7_v  (drv7_v),
    .drvf_en (drvf_en),
    .drvf_v  (drvf_v),
    .p7_lvl  (p7_lvl),
    .pf_lvl  (pf_lvl)
  );

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // bounded wait for hready high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (rsp.hreadyout !== 1'b1 && n < 64);
    if (rsp.hreadyout !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask : wait_rdy

  // one single-word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic rmw);
    req_d <= '{hsel: 1'b1, haddr: {24'h0, a}, htrans: 2'b10, hwrite: wr, hsize: 3'h2, default: '0};
    hrmw <= rmw;
    wait_rdy();
    req_d <= '{hwdata: d, default: '0};
    hrmw <= 1'b0;
    wait_rdy();
    rd = rsp.hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic rmw, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rmw);
    chk(what, rd, exp);
  endtask : rdc

  task automatic step(input int n);
    repeat (n) @(posedge hclk);
  endtask : step

  // main sequence
  initial begin
    hresetn = 1'b0;
    req_d = '0;
    hrmw = 1'b0;
    periph = '0;
    standby = 1'b0;
    wake_en = 3'h0;
    drv7_en = 8'h00;
    drv7_v = 8'h00;
    drvf_en = 3'h0;
    drvf_v = 3'h0;
    bad_count = 0;
    checks_done = 0;
    step(2);
    hresetn <= 1'b1;
    // every register and one unmapped word read zero after reset
    for (int a = 0; a <= 8'h18; a += 4) rdc("reset value", 8'(a), 1'b1, 32'h0);
    chk("p7 oe after reset", 32'(p7_pad.oe), 32'h0);
    chk("hresp", 32'(rsp.hresp), 32'h0);
    wr(8'h18, 32'hff);
    rdc("unmapped", 8'h18, 1'b0, 32'h0);
    // output port: latch on the pins, open-drain high floats
    wr(A_P7_DIR, 32'hff);
    wr(A_P7_DAT, 32'ha5);
    eo = 8'hff & ~(P7_OPEN_DRAIN & 8'ha5);
    step(1);
    chk("p7 oe", 32'(p7_pad.oe), 32'(eo));
    chk("p7 out", 32'(p7_pad.out & eo), 32'(8'ha5 & eo));
    rdc("p7 dat out", A_P7_DAT, 1'b0, 32'ha5);
    // input port fed by a peripheral-input pin; direction cleared first
    wr(A_P7_DIR, 32'h00);
    drv7_en <= 8'hff;
    drv7_v <= 8'h3c;
    wr(A_P7_DAT, 32'h81);
    step(1);
    chk("p7 oe input", 32'(p7_pad.oe), 32'h0);
    step(3);
    rdc("p7 pin read", A_P7_DAT, 1'b0, 32'h3c);
    rdc("p7 rmw read", A_P7_DAT, 1'b1, 32'h81);
    chk("p7 periph in", 32'(p7_to_per), 32'h3c);
    drv7_en <= 8'h00;
    // peripheral output takes over pins 0 and 6
    wr(A_P7_DIR, 32'hff);
    wr(A_P7_DAT, 32'h00);
    periph <= '{oe: 8'h41, out: 8'h40};
    step(2);
    chk("periph oe", 32'(p7_pad.oe & 8'h41), 32'h41);
    chk("periph out", 32'(p7_pad.out & 8'h41), 32'h40);
    step(2);
    rdc("periph pin read", A_P7_DAT, 1'b0, 32'h40);
    rdc("periph rmw read", A_P7_DAT, 1'b1, 32'h0);
    periph <= '0;
    // pull-ups: bus pins have none, low drivers drop theirs
    wr(A_P7_DIR, 32'h00);
    wr(A_P7_PUL, 32'hff);
    rdc("p7 pull reg", A_P7_PUL, 1'b0, 32'hf3);
    chk("p7 pull in", 32'(p7_pad.pull), 32'hf3);
    wr(A_P7_DIR, 32'hff);
    wr(A_P7_DAT, 32'h0f);
    step(1);
    chk("p7 pull low", 32'(p7_pad.pull), 32'h03);
    // standby: state bit clear keeps pins, set floats and blocks
    wr(A_P7_DAT, 32'hff);
    standby <= 1'b1;
    step(2);
    chk("standby keep oe", 32'(p7_pad.oe), 32'hf3);
    chk("standby keep out", 32'(p7_pad.out & 8'hf3), 32'hf3);
    wr(A_CTL, 32'h1);
    step(2);
    chk("standby float", 32'(p7_pad.oe), 32'h0);
    drv7_en <= 8'hff;
    drv7_v <= 8'hff;
    drvf_en <= 3'h7;
    drvf_v <= 3'h7;
    wake_en <= 3'b101;
    step(6);
    chk("standby p7 in", 32'(p7_to_per), 32'h90);
    chk("standby pf in", 32'(pf_to_per), 32'h0);
    wake_en <= 3'b010;
    step(4);
    chk("standby p7 wake clk", 32'(p7_to_per), 32'h20);
    drv7_en <= 8'h00;
    drvf_en <= 3'h0;
    standby <= 1'b0;
    wr(A_CTL, 32'h0);
    // three-pin port, open-drain bit 2 and the reset pin
    wr(A_PF_DIR, 32'h7);
    wr(A_PF_DAT, 32'h3);
    step(1);
    chk("pf oe", 32'(pf_pad.oe), 32'h7);
    chk("pf out", 32'(pf_pad.out), 32'h3);
    rdc("pf dir", A_PF_DIR, 1'b0, 32'h7);
    wr(A_CTL, 32'h2);
    step(2);
    chk("pf rst oe", 32'(pf_pad.oe), 32'h3);
    wr(A_CTL, 32'h0);
    wr(A_PF_DAT, 32'h7);
    step(1);
    chk("pf od oe", 32'(pf_pad.oe), 32'h3);
    wr(A_PF_DIR, 32'h0);
    drvf_en <= 3'h7;
    drvf_v <= 3'h5;
    wr(A_CTL, 32'h2);
    step(4);
    rdc("pf rst read", A_PF_DAT, 1'b0, 32'h1);
    rdc("pf rmw read", A_PF_DAT, 1'b1, 32'h7);
    chk("pf periph in", 32'(pf_to_per), 32'h1);
    tally_and_finish();
  end
endmodule : gpp_top_tb
